// *** include/utc_pkg.sv ***
// Shared constants and types of the transmit control block.
// Assumes a 32-bit APB master on the core clock and a baud-rate clock on the link side.
package utc_pkg;

   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] TSC_ADDR = 8'h98;
   localparam logic [7:0] DATA_ADDR = 8'h9C;
   localparam logic [7:0] CTL_ADDR = 8'hA0;

   // ==========================================
   // Transmit status and control fields
   localparam int CLOCK_SOURCE_SELECT_POS = 7;
   localparam int TX9_POS = 6;
   localparam int TRANSMIT_ENABLE_BIT_POS = 5;
   localparam int SYNC_POS = 4;
   localparam int HIGH_BAUD_SELECT_POS = 2;
   localparam int EMPTY_POS = 1;
   localparam int NINTH_TRANSMIT_BIT_POS = 0;
   localparam logic [7:0] TSC_RESET = 8'h02;

   // ==========================================
   // Port control fields
   localparam int SERIAL_PORT_ENABLE_BIT_POS = 7;
   localparam int DIR_LO_POS = 0;

   // ==========================================
   // Link clocks per asynchronous bit, minus one
   localparam logic [1:0] TICK_LOW_LAST = 2'h3;
   localparam logic [1:0] TICK_HIGH_LAST = 2'h0;

   // Bits per frame
   localparam logic [3:0] ASYNC8_BITS = 4'hA;
   localparam logic [3:0] ASYNC9_BITS = 4'hB;
   localparam logic [3:0] SYNC8_BITS = 4'h8;
   localparam logic [3:0] SYNC9_BITS = 4'h9;

   // Character and mode captured at the moment a send is accepted
   typedef struct packed {
      logic high_baud_select;
      logic sync;
      logic clock_source_select;
      logic tx9;
      logic ninth;
      logic [7:0] data;
   } utc_word_type;

   // Safe default: synchronous slave, so no pin is driven before a first send
   localparam utc_word_type WORD_RESET = 13'h0800;

endpackage

// *** rtl/utc_tx_control.sv ***
// Transmit control of a serial transceiver: APB registers on clk, shifter on link_clk.
// Assumes link_clk is the baud clock and the port pins are resolved by the surroundings.
//
// Summary of operation
// - Asynchronous mode sends on its own pin while the receive pin stays free.
// - Synchronous mode is half-duplex, master drives the clock, slave follows it.
// - Pins serve the port only with port enable and both direction bits set.
// - A ninth bit per character lets receivers detect address characters.
// - With nine-bit selected, the stored ninth bit goes out as the extra bit.
module utc_tx_control #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic transmit_clock_pin_i,
   output logic transmit_clock_pin_o,
   output logic transmit_clock_pin_oe_n,
   input wire logic receive_data_pin_i,
   output logic receive_data_pin_o,
   output logic receive_data_pin_oe_n
);

   if (ADDR_W < 8) begin : g_chk
      $error("ADDR_W must be at least 8");
   end

   // ==========================================
   // Core domain state
   typedef struct packed {
      logic clock_source_select;
      logic tx9;
      logic transmit_enable_bit;
      logic sync;
      logic high_baud_select;
      logic ninth_transmit_bit;
      logic serial_port_enable_bit;
      logic [1:0] dir;
      logic [7:0] data;
      utc_pkg::utc_word_type pend;
      logic req;
      logic [2:0] ack_s;
      logic ack_seen;
      logic [31:0] rdata;
   } utc_core_type;

   typedef enum logic {LK_IDLE, LK_SEND} utc_lstate_type;

   // ==========================================
   // Link domain state
   typedef struct packed {
      logic [2:0] req_s;
      logic req_seen;
      logic ack;
      logic [2:0] act_s;
      logic act;
      logic [2:0] ck_s;
      logic ck_lvl;
      utc_lstate_type st;
      utc_pkg::utc_word_type w;
      logic [10:0] sh;
      logic [3:0] left;
      logic [1:0] tick;
      logic ck_o;
   } utc_link_type;

   utc_core_type cq, cd;
   utc_link_type lq, ld;
   logic empty, pin_act, setup, wr_acc, mapped, accept;
   logic start, fall, bit_done;
   logic [1:0] tick_last;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
      hit = (a == ADDR_W'(r));
   endfunction

   assign empty = (cq.req == cq.ack_seen);
   assign pin_act = cq.serial_port_enable_bit & (&cq.dir);
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign mapped = hit(paddr, utc_pkg::TSC_ADDR) | hit(paddr, utc_pkg::DATA_ADDR)
                 | hit(paddr, utc_pkg::CTL_ADDR);
   // A character is taken only when the shifter is free and the port is owned
   assign accept = wr_acc & hit(paddr, utc_pkg::DATA_ADDR) & empty & cq.transmit_enable_bit & pin_act;

   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = cq.rdata;

   // ==========================================
   // Core next state
   always_comb begin
      cd = cq;
      cd.ack_s = {cq.ack_s[1:0], lq.ack};
      if (cq.ack_s[1] == cq.ack_s[2]) begin
         cd.ack_seen = cq.ack_s[2];
      end
      if (setup & ~pwrite) begin
         cd.rdata = '0;
         if (hit(paddr, utc_pkg::TSC_ADDR)) begin
            cd.rdata[utc_pkg::CLOCK_SOURCE_SELECT_POS] = cq.clock_source_select;
            cd.rdata[utc_pkg::TX9_POS] = cq.tx9;
            cd.rdata[utc_pkg::TRANSMIT_ENABLE_BIT_POS] = cq.transmit_enable_bit;
            cd.rdata[utc_pkg::SYNC_POS] = cq.sync;
            cd.rdata[utc_pkg::HIGH_BAUD_SELECT_POS] = cq.high_baud_select;
            cd.rdata[utc_pkg::EMPTY_POS] = empty;
            cd.rdata[utc_pkg::NINTH_TRANSMIT_BIT_POS] = cq.ninth_transmit_bit;
         end else if (hit(paddr, utc_pkg::DATA_ADDR)) begin
            cd.rdata[7:0] = cq.data;
         end else if (hit(paddr, utc_pkg::CTL_ADDR)) begin
            cd.rdata[utc_pkg::SERIAL_PORT_ENABLE_BIT_POS] = cq.serial_port_enable_bit;
            cd.rdata[utc_pkg::DIR_LO_POS +: 2] = cq.dir;
         end
      end
      if (wr_acc & hit(paddr, utc_pkg::TSC_ADDR)) begin
         cd.clock_source_select = pwdata[utc_pkg::CLOCK_SOURCE_SELECT_POS];
         cd.tx9 = pwdata[utc_pkg::TX9_POS];
         cd.transmit_enable_bit = pwdata[utc_pkg::TRANSMIT_ENABLE_BIT_POS];
         cd.sync = pwdata[utc_pkg::SYNC_POS];
         cd.high_baud_select = pwdata[utc_pkg::HIGH_BAUD_SELECT_POS];
         cd.ninth_transmit_bit = pwdata[utc_pkg::NINTH_TRANSMIT_BIT_POS];
      end
      if (wr_acc & hit(paddr, utc_pkg::DATA_ADDR)) begin
         cd.data = pwdata[7:0];
      end
      if (wr_acc & hit(paddr, utc_pkg::CTL_ADDR)) begin
         cd.serial_port_enable_bit = pwdata[utc_pkg::SERIAL_PORT_ENABLE_BIT_POS];
         cd.dir = pwdata[utc_pkg::DIR_LO_POS +: 2];
      end
      // Snapshot held stable until the link toggles back, so it crosses safely
      if (accept) begin
         cd.pend = {cq.high_baud_select, cq.sync, cq.clock_source_select, cq.tx9, cq.ninth_transmit_bit, pwdata[7:0]};
         cd.req = ~cq.req;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cq <= '0;
         cq.pend <= utc_pkg::WORD_RESET;
      end else begin
         cq <= cd;
      end
   end

   // ==========================================
   // Link next state
   assign start = (lq.req_s[1] == lq.req_s[2]) & (lq.req_s[2] != lq.req_seen);
   assign fall = (lq.ck_s[1] == lq.ck_s[2]) & lq.ck_lvl & ~lq.ck_s[2];
   assign tick_last = lq.w.high_baud_select ? utc_pkg::TICK_HIGH_LAST : utc_pkg::TICK_LOW_LAST;

   always_comb begin
      ld = lq;
      ld.req_s = {lq.req_s[1:0], cq.req};
      ld.act_s = {lq.act_s[1:0], pin_act};
      ld.ck_s = {lq.ck_s[1:0], transmit_clock_pin_i};
      bit_done = 1'b0;
      if (lq.req_s[1] == lq.req_s[2]) begin
         ld.req_seen = lq.req_s[2];
      end
      if (lq.act_s[1] == lq.act_s[2]) begin
         ld.act = lq.act_s[2];
      end
      if (lq.ck_s[1] == lq.ck_s[2]) begin
         ld.ck_lvl = lq.ck_s[2];
      end
      unique case (lq.st)
         LK_IDLE: begin
            if (start) begin
               ld.w = cq.pend;
               ld.tick = '0;
               ld.ck_o = 1'b0;
               ld.st = LK_SEND;
               if (!cq.pend.sync) begin
                  // Stop, optional ninth bit, data LSB first, start
                  ld.sh = cq.pend.tx9 ? {1'b1, cq.pend.ninth, cq.pend.data, 1'b0}
                                      : {2'b11, cq.pend.data, 1'b0};
                  ld.left = cq.pend.tx9 ? utc_pkg::ASYNC9_BITS : utc_pkg::ASYNC8_BITS;
               end else begin
                  ld.sh = {2'b11, cq.pend.ninth, cq.pend.data};
                  ld.left = cq.pend.tx9 ? utc_pkg::SYNC9_BITS : utc_pkg::SYNC8_BITS;
               end
            end
         end
         LK_SEND: begin
            if (!lq.w.sync) begin
               bit_done = (lq.tick == tick_last);
               ld.tick = bit_done ? 2'h0 : lq.tick + 2'h1;
            end else if (lq.w.clock_source_select) begin
               // Master: data set while clock low, sampled by the partner on the rise
               ld.ck_o = ~lq.ck_o;
               bit_done = lq.ck_o;
            end else begin
               bit_done = fall;
            end
            if (bit_done) begin
               ld.sh = {1'b1, lq.sh[10:1]};
               ld.left = lq.left - 4'h1;
               if (lq.left == 4'h1) begin
                  ld.st = LK_IDLE;
                  ld.ack = ~lq.ack;
               end
            end
            // Losing the pins ends the frame at once
            if (!lq.act) begin
               ld.st = LK_IDLE;
               ld.ack = ~lq.ack;
               ld.sh = '1;
               ld.ck_o = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         lq <= '0;
         lq.w <= utc_pkg::WORD_RESET;
         lq.sh <= '1;
         lq.st <= LK_IDLE;
      end else begin
         lq <= ld;
      end
   end

   // ==========================================
   // Pins: async uses the clock pin as output and never the data pin
   assign transmit_clock_pin_o = lq.w.sync ? lq.ck_o : lq.sh[0];
   assign transmit_clock_pin_oe_n = ~(lq.act & (~lq.w.sync | lq.w.clock_source_select));
   assign receive_data_pin_o = lq.sh[0];
   assign receive_data_pin_oe_n = ~(lq.act & lq.w.sync & (lq.st == LK_SEND));

   // ==========================================
   // Checks
   sequence s_data_accept;
      accept;
   endsequence

   sequence s_async_start;
      (lq.st == LK_IDLE) && start && !cq.pend.sync && lq.act;
   endsequence

   a_async_start_bit: assert property (@(posedge link_clk) disable iff (!reset_n)
      s_async_start |=> !transmit_clock_pin_o && receive_data_pin_oe_n
                        && !transmit_clock_pin_oe_n)
      else $error("async frame did not open with a start bit on a free rx pin");

   a_master_clock_out: assert property (@(posedge link_clk) disable iff (!reset_n)
      (lq.st == LK_SEND) && lq.w.sync && lq.w.clock_source_select && lq.act && !lq.ck_o
      |=> transmit_clock_pin_o && !receive_data_pin_oe_n)
      else $error("sync master did not raise its clock while driving data");

   a_pin_release: assert property (@(posedge link_clk) disable iff (!reset_n)
      !lq.act |-> transmit_clock_pin_oe_n && receive_data_pin_oe_n ##1 (lq.st == LK_IDLE))
      else $error("pins held without port ownership");

   a_ninth_capture: assert property (@(posedge clk) disable iff (!reset_n)
      s_data_accept |=> cq.pend.ninth == $past(cq.ninth_transmit_bit) && cq.pend.tx9 == $past(cq.tx9))
      else $error("ninth bit not captured with the character");

   a_ninth_on_line: assert property (@(posedge link_clk) disable iff (!reset_n)
      (lq.st == LK_SEND) && !lq.w.sync && lq.w.tx9 && (lq.left == 4'h2)
      |-> transmit_clock_pin_o == lq.w.ninth)
      else $error("ninth bit missing before the stop bit");

   a_empty_flag: assert property (@(posedge clk) disable iff (!reset_n)
      s_data_accept |=> !empty)
      else $error("empty flag stayed set after a send was accepted");

endmodule

// *** sim/tb_usart_transmit_control.sv ***
// Bench of the transmit control block: APB master, pin resolution, far-end receiver.
// Assumes pull-ups on both port pins and zero-wait APB answers.
module tb_usart_transmit_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset_n, link_clk, psel, penable, pwrite, slv, got, sync_m, nine;
   logic ck_o, ck_oe_n, dt_o, dt_oe_n;
   logic [7:0] paddr, tsc, d;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr;
   logic [2:0] blen;
   logic [8:0] word, w;
   logic [8:0] exp_q[$];
   logic [7:0] ctl_v[3] = '{8'h81, 8'h82, 8'h03};
   int miscompares, n_compared, seed, n;
   wire ck_w = ck_oe_n ? 1'b1 : ck_o;
   wire dt_w = dt_oe_n ? 1'b1 : dt_o;

   utc_tx_control dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .transmit_clock_pin_i(ck_w),
      .transmit_clock_pin_o(ck_o), .transmit_clock_pin_oe_n(ck_oe_n),
      .receive_data_pin_i(dt_w), .receive_data_pin_o(dt_o), .receive_data_pin_oe_n(dt_oe_n));
   utc_far_end far (.link_clk(link_clk), .line(ck_w), .data_line(dt_w), .bit_len(blen),
      .nine(nine), .sync_mode(sync_m), .got(got), .word(word));

   // ==========================================
   // Clocks, checks and APB
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #6 link_clk = ~link_clk;
   end
   task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
      n_compared++;
      if (act !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, act, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
      if (k >= 50) miscompares++;
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic complete_run;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // With go set, the second data write lands while the shifter is busy and must be dropped
   task automatic send(input logic go);
      apb(1'b1, utc_pkg::TSC_ADDR, {24'h0, tsc});
      apb(1'b1, utc_pkg::DATA_ADDR, {24'h0, d});
      if (go) exp_q.push_back({tsc[utc_pkg::TX9_POS] & tsc[0], d});
      apb(1'b1, utc_pkg::DATA_ADDR, {24'h0, ~d});
      apb(1'b0, utc_pkg::TSC_ADDR, 32'h0);
      check(rd[utc_pkg::EMPTY_POS], !go, "empty flag");
      n = 0;
      do apb(1'b0, utc_pkg::TSC_ADDR, 32'h0); while (rd[1] !== 1'b1 && ++n < 100);
      if (n >= 100) miscompares++;
      repeat (5) @(posedge clk);
   endtask

   always @(posedge got) begin
      w = exp_q.size() ? exp_q.pop_front() : ~word;
      check({23'h0, word}, {23'h0, w}, "frame");
   end
   initial begin
      #5ms;
      miscompares++;
      complete_run();
   end

   // ==========================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sync_m, nine, blen} = 5'h04;
      seed = 32'h8801AF36;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, utc_pkg::TSC_ADDR, 32'h0);
      check(rd, 32'h02, "tsc reset");
      apb(1'b0, 8'hF0, 32'h0);
      check(rd, 32'h0, "unmapped data");
      check({31'h0, slv}, 32'h1, "unmapped error");
      apb(1'b1, utc_pkg::TSC_ADDR, 32'hFF);
      apb(1'b0, utc_pkg::TSC_ADDR, 32'h0);
      check(rd, 32'hF7, "tsc access");
      foreach (ctl_v[i]) begin
         apb(1'b1, utc_pkg::CTL_ADDR, {24'h0, ctl_v[i]});
         tsc = 8'h20;
         d = 8'h5A;
         send(1'b0);
         check({ck_oe_n, dt_oe_n}, 2'h3, "pins unowned");
      end
      apb(1'b1, utc_pkg::CTL_ADDR, 32'h83);
      repeat (4) @(posedge clk);
      for (int m = 0; m < 8; m++) begin
         {sync_m, nine} = {m[2], m[1]};
         blen = m[0] ? 3'h1 : 3'h4;
         d = 8'($random(seed));
         tsc = {m[2], m[1], 1'b1, m[2], 1'b0, m[0], 1'b0, 1'($random(seed))};
         send(1'b1);
         if (m[2]) check(ck_oe_n, 1'b0, "sync clock");
         else check(dt_oe_n, 1'b1, "rx pin free");
      end
      check(exp_q.size(), 0, "frames left");
      complete_run();
   end
endmodule

// *** sim/utc_far_end.sv ***
// Far-end serial receiver: decodes asynchronous frames and synchronous master frames.
// Assumes pins resolved with pull-ups by the bench and mode/length set before each send.
module utc_far_end (
   input wire logic link_clk,
   input wire logic line,
   input wire logic data_line,
   input wire logic [2:0] bit_len,
   input wire logic nine,
   input wire logic sync_mode,
   output logic got,
   output logic [8:0] word
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] w;
   // ==========================================
   // Receiver
   // Sampling on the falling edge keeps clear of the shifter's launch edge
   initial begin
      got = 1'b0;
      word = 9'h000;
      forever begin
         w = 9'h000;
         @(negedge link_clk iff (sync_mode || line === 1'b0));
         for (int i = 0; i < 8 + nine; i++) begin
            if (sync_mode) begin
               @(posedge line);
               w[i] = data_line;
            end else begin
               repeat (bit_len) @(negedge link_clk);
               w[i] = line;
            end
         end
         if (!sync_mode) begin
            repeat (bit_len) @(negedge link_clk);
            // A bad stop bit spoils the character on purpose
            if (line !== 1'b1) w = ~w;
         end
         word = w;
         got = 1'b1;
         #5 got = 1'b0;
      end
   end
endmodule
